// [mom_regs.vh]
`ifndef MOM_REGS_VH
`define MOM_REGS_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
// sys_clk rate in Hz (period 20 ns)
`define MOM_CLK_HZ 50000000
// phase increment per full-scale LSB: 2^32 * (1 MHz / 32768) / 50 MHz
`define MOM_FREQ_LSB_INC 12'ha3d
// half of the above, bipolar span is 0..1 MHz over twice the range
`define MOM_FREQ_HALF_INC 12'h51f
// increment ceiling, 12.5 MHz, keeps the square wave well under clk/2
`define MOM_INC_MAX 40'h0040000000

// ---------------------------------------------------------------
// number formats
// ---------------------------------------------------------------
`define MOM_FS_POS 16'h7fff
`define MOM_FS_NEG 16'h8001
// calibration gains are q2.14, 1.0 = 16384
`define MOM_CAL_SHIFT 14
// position result is q1.15
`define MOM_POS_SHIFT 15
// scale factor is in thousandths: 1 = 0.001, 2000 = 2.0
`define MOM_SCALE_ONE 11'h3e8
`define MOM_SCALE_MIN 12'h001
`define MOM_SCALE_MAX 12'h7d0

// ---------------------------------------------------------------
// selections
// ---------------------------------------------------------------
`define MOM_SRC_CUR 2'h0
`define MOM_SRC_COMP 2'h1
`define MOM_SRC_POS 2'h2
`define MOM_FMODE_BIP 2'h0
`define MOM_FMODE_POS 2'h1
`define MOM_FMODE_NEG 2'h2
`define MOM_FMODE_ABS 2'h3
// analog outputs that the servo may take over
`define MOM_SERVO_CHANS 2

`endif

// [mom_chan.v]
`include "mom_regs.vh"
`default_nettype none

module mom_chan (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire load,
    input wire [15:0] cur,
    input wire [15:0] comp,
    input wire [15:0] pos,
    input wire [1:0] sel,
    input wire [1:0] fmode,
    input wire [11:0] scale,
    input wire servo_sel,
    input wire [15:0] servo_code,
    output reg [15:0] analog,
    output wire ttl,
    output wire scale_clamped
);

// ---------------------------------------------------------------
// scale and source
// ---------------------------------------------------------------
wire [11:0] scl = (scale < `MOM_SCALE_MIN) ? `MOM_SCALE_MIN :
                  (scale > `MOM_SCALE_MAX) ? `MOM_SCALE_MAX : scale;
assign scale_clamped = (scale < `MOM_SCALE_MIN) || (scale > `MOM_SCALE_MAX);

reg [15:0] src;
always @* begin
    case (sel)
        `MOM_SRC_CUR: src = cur;
        `MOM_SRC_COMP: src = comp;
        `MOM_SRC_POS: src = pos;
        default: src = cur;
    endcase
end

// reading / scale, independent of compensation gains
wire signed [26:0] prod = $signed(src) * $signed({1'b0, `MOM_SCALE_ONE});
wire signed [26:0] mapped = prod / $signed({1'b0, scl});

// ---------------------------------------------------------------
// analog code, saturating
// ---------------------------------------------------------------
wire signed [26:0] fs_pos = $signed({11'h000, `MOM_FS_POS});
wire signed [26:0] fs_neg = -fs_pos;
wire [15:0] ana_sat = (mapped > fs_pos) ? `MOM_FS_POS :
                      (mapped < fs_neg) ? `MOM_FS_NEG : mapped[15:0];

// ---------------------------------------------------------------
// frequency increment
// ---------------------------------------------------------------
wire signed [27:0] bip = $signed({mapped[26], mapped}) + $signed({12'h000, `MOM_FS_POS});
wire [26:0] mag = mapped[26] ? -mapped : mapped;
reg [39:0] next_inc_raw;
always @* begin
    case (fmode)
        `MOM_FMODE_BIP: next_inc_raw = bip[27] ? 40'h0 :
                         bip[26:0] * `MOM_FREQ_HALF_INC;
        `MOM_FMODE_POS: next_inc_raw = mapped[26] ? 40'h0 :
                         mapped[26:0] * `MOM_FREQ_LSB_INC;
        `MOM_FMODE_NEG: next_inc_raw = mapped[26] ? mag * `MOM_FREQ_LSB_INC : 40'h0;
        `MOM_FMODE_ABS: next_inc_raw = mag * `MOM_FREQ_LSB_INC;
        default: next_inc_raw = 40'h0;
    endcase
end
// over-range allowed up to a safe ceiling for small scale factors
wire [39:0] inc_sat = (next_inc_raw > `MOM_INC_MAX) ? `MOM_INC_MAX : next_inc_raw;
wire [31:0] next_inc = inc_sat[31:0];

reg [31:0] inc;
reg [31:0] phase;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        inc <= 32'h0;
        phase <= 32'h0;
        analog <= 16'h0;
    end else if (ce) begin
        phase <= phase + inc;
        if (load)
            inc <= next_inc;
        if (servo_sel)
            analog <= servo_code;
        else if (load)
            analog <= ana_sat;
    end
end

// msb of the accumulator: equal high and low halves
assign ttl = phase[31];

endmodule // mom_chan

`default_nettype wire

// [mom_mapper.v]
// How it works
// - each ttl output is a 50% duty square wave at the mapped frequency
// - unity scale maps -full scale to bottom and +full scale to top linearly
// - position -1..+1 maps linearly onto the whole analog span
// - scale factor is limited to 0.001..2.0; outside values are clamped
// - output equals reading over full scale, over scale, times span
// - each output selects calibrated current, compensated current or position
// - scale factor applies independently of sensor compensation
// - bipolar frequency: zero gives midpoint, positive up, negative down to zero
// - positive frequency mode maps only positive inputs; negatives give no output
// - negative frequency mode maps negative magnitude; positives give no output
// - absolute frequency mode maps input magnitude from zero to maximum
// - scale applies to frequency too; small scales may exceed nominal maximum
// - enabled installed servo drives analog outputs 0 and 1 instead of mapping; outputs 2 and 3 keep mapping
// - sources come from average, range calibration, compensation, then position
`include "mom_regs.vh"
`default_nettype none

module mom_mapper (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire sample_valid,
    input wire [63:0] raw_sample,
    input wire [3:0] integ_shift,
    input wire [63:0] cal_gain,
    input wire [63:0] cal_offset,
    input wire [63:0] sens_gain,
    input wire [63:0] sens_offset,
    input wire quad_mode,
    input wire [7:0] source_sel,
    input wire [7:0] freq_mode,
    input wire [47:0] scale_milli,
    input wire servo_installed,
    input wire servo_en,
    input wire [31:0] servo_code,
    output wire [63:0] analog_code,
    output wire [3:0] ttl_out,
    output wire [3:0] scale_clamped,
    output reg result_valid,
    output reg [63:0] cur_result,
    output reg [63:0] comp_result,
    output reg [31:0] pos_result
);

// ---------------------------------------------------------------
// helpers
// ---------------------------------------------------------------
function [15:0] sat16;
    input signed [47:0] v;
    begin
        if (v > $signed({32'h0, `MOM_FS_POS}))
            sat16 = `MOM_FS_POS;
        else if (v < -$signed({32'h0, `MOM_FS_POS}))
            sat16 = `MOM_FS_NEG;
        else
            sat16 = v[15:0];
    end
endfunction

// difference over sum in q1.15, zero when the sum is not positive
function [15:0] pos_div;
    input signed [17:0] n;
    input signed [17:0] d;
    reg signed [32:0] q;
    begin
        q = 33'h0;
        if (d > 18'sh0)
            q = $signed({n, 15'h0}) / d;
        pos_div = sat16({{15{q[32]}}, q});
    end
endfunction

// ---------------------------------------------------------------
// integration counter, shared by all channels
// ---------------------------------------------------------------
reg [15:0] cnt;
reg v1;
reg v2;
reg v3;
// count compares to the live shift: change it only right after a result
wire [15:0] cnt_last = (16'h0001 << integ_shift) - 16'h0001;
wire period_end = sample_valid && (cnt == cnt_last);

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        cnt <= 16'h0;
        v1 <= 1'b0;
        v2 <= 1'b0;
        v3 <= 1'b0;
        result_valid <= 1'b0;
    end else if (ce) begin
        if (sample_valid)
            cnt <= period_end ? 16'h0 : cnt + 16'h0001;
        v1 <= period_end;
        v2 <= v1;
        v3 <= v2;
        result_valid <= v3;
    end
end

// ---------------------------------------------------------------
// per-channel average, calibration and compensation
// ---------------------------------------------------------------
wire [63:0] cal_bus;
wire [63:0] comp_bus;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
        // 32 bits hold 2^15 full-scale samples
        reg signed [31:0] acc;
        reg signed [15:0] avg;
        reg [15:0] cal;
        reg [15:0] cmp;
        wire signed [15:0] smp = raw_sample[16*g +: 16];
        wire signed [31:0] acc_sum = acc + {{16{smp[15]}}, smp};
        wire signed [31:0] avg_next = acc_sum >>> integ_shift;
        wire signed [15:0] coff = cal_offset[16*g +: 16];
        wire signed [15:0] cgain = cal_gain[16*g +: 16];
        wire signed [15:0] soff = sens_offset[16*g +: 16];
        wire signed [15:0] sgain = sens_gain[16*g +: 16];
        wire signed [16:0] cdiff = avg - coff;
        wire signed [32:0] cprod = cdiff * cgain;
        wire signed [32:0] cshift = cprod >>> `MOM_CAL_SHIFT;
        wire signed [16:0] sdiff = $signed(cal) - soff;
        wire signed [32:0] sprod = sdiff * sgain;
        wire signed [32:0] sshift = sprod >>> `MOM_CAL_SHIFT;

        always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                acc <= 32'h0;
                avg <= 16'h0;
                cal <= 16'h0;
                cmp <= 16'h0;
            end else if (ce) begin
                if (sample_valid) begin
                    acc <= period_end ? 32'h0 : acc_sum;
                    if (period_end)
                        avg <= avg_next[15:0];
                end
                if (v1)
                    cal <= sat16({{15{cshift[32]}}, cshift});
                if (v2)
                    cmp <= sat16({{15{sshift[32]}}, sshift});
            end
        end

        assign cal_bus[16*g +: 16] = cal;
        assign comp_bus[16*g +: 16] = cmp;
    end
endgenerate

// ---------------------------------------------------------------
// position, quadrant or split
// ---------------------------------------------------------------
wire signed [17:0] ch_a = $signed(comp_bus[15:0]);
wire signed [17:0] ch_b = $signed(comp_bus[31:16]);
wire signed [17:0] ch_c = $signed(comp_bus[47:32]);
wire signed [17:0] ch_d = $signed(comp_bus[63:48]);

// 18 bits hold any sum of four full-scale channels
wire signed [17:0] sum_ad = ch_a + ch_d;
wire signed [17:0] sum_bc = ch_b + ch_c;
wire signed [17:0] sum_ab = ch_a + ch_b;
wire signed [17:0] sum_cd = ch_c + ch_d;
wire signed [17:0] sum_all = sum_ad + sum_bc;

// quadrant compares pad pairs both ways, split pairs a/d and b/c
wire signed [17:0] quad_x = sum_ad - sum_bc;
wire signed [17:0] quad_y = sum_ab - sum_cd;
wire signed [17:0] split_x = ch_a - ch_d;
wire signed [17:0] split_y = ch_b - ch_c;

wire signed [17:0] x_num = quad_mode ? quad_x : split_x;
wire signed [17:0] x_den = quad_mode ? sum_all : sum_ad;
wire signed [17:0] y_num = quad_mode ? quad_y : split_y;
wire signed [17:0] y_den = quad_mode ? sum_all : sum_bc;

// all result groups move together so a channel never mixes two periods, except one-sample periods ending on consecutive cycles
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        cur_result <= 64'h0;
        comp_result <= 64'h0;
        pos_result <= 32'h0;
    end else if (ce && v3) begin
        cur_result <= cal_bus;
        comp_result <= comp_bus;
        pos_result <= {pos_div(y_num, y_den), pos_div(x_num, x_den)};
    end
end

// ---------------------------------------------------------------
// output channels
// ---------------------------------------------------------------
// x axis feeds outputs 0 and 2, y axis outputs 1 and 3
generate
    for (g = 0; g < 4; g = g + 1) begin : g_out
        wire servo_sel = servo_installed && servo_en && (g < `MOM_SERVO_CHANS);
        mom_chan u_chan (
            .sys_clk(sys_clk),
            .rst(rst),
            .ce(ce),
            .load(result_valid),
            .cur(cur_result[16*g +: 16]),
            .comp(comp_result[16*g +: 16]),
            .pos(pos_result[16*(g%2) +: 16]),
            .sel(source_sel[2*g +: 2]),
            .fmode(freq_mode[2*g +: 2]),
            .scale(scale_milli[12*g +: 12]),
            .servo_sel(servo_sel),
            .servo_code(servo_code[16*(g%2) +: 16]),
            .analog(analog_code[16*g +: 16]),
            .ttl(ttl_out[g]),
            .scale_clamped(scale_clamped[g])
        );
    end
endgenerate

endmodule // mom_mapper

`default_nettype wire

// [mom_mapper_asserts.sv]
`default_nettype none
module mom_mapper_chk (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire sample_valid,
    input wire [3:0] integ_shift,
    input wire [47:0] scale_milli,
    input wire servo_installed,
    input wire servo_en,
    input wire [31:0] servo_code,
    input wire [63:0] analog_code,
    input wire [3:0] ttl_out,
    input wire [3:0] scale_clamped,
    input wire result_valid,
    input wire [31:0] pos_result
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire servo_on = servo_installed && servo_en;
    function automatic logic bad(input logic [11:0] s);
        return s == 12'h000 || s > 12'h7d0;
    endfunction
    sequence take_s;
        ce && sample_valid && integ_shift == 4'h0;
    endsequence
    sequence pipe_s;
        (ce && integ_shift == 4'h0) [*3];
    endsequence
    // ------
    // checks
    // ------
    result_lag_a: assert property (take_s ##1 pipe_s |=> result_valid)
        else $error("result late");
    analog_hold_a: assert property (ce && !result_valid && !servo_on |=> $stable(analog_code))
        else $error("analog moved without result");
    servo_take_a: assert property (ce && servo_on |=> analog_code[31:0] == $past(servo_code))
        else $error("servo code not on outputs 0 and 1");
    servo_spare_a: assert property (ce && servo_on && !result_valid |=> $stable(analog_code[63:32]))
        else $error("outputs 2 and 3 disturbed by servo");
    span_sat_a: assert property (analog_code[47:32] != 16'h8000 && analog_code[63:48] != 16'h8000)
        else $error("analog code beyond span");
    pos_range_a: assert property (pos_result[15:0] != 16'h8000 && pos_result[31:16] != 16'h8000)
        else $error("position beyond range");
    // the increment ceiling keeps each level at least two cycles
    // history from before reset release is not meaningful
    ttl_ceiling_a: assert property (ce && !rst && !$past(rst) |->
        ((ttl_out ^ $past(ttl_out)) & ($past(ttl_out) ^ $past(ttl_out, 2))) == 4'h0)
        else $error("ttl toggled on consecutive cycles");
    scale_clamp_a: assert property (scale_clamped == {bad(scale_milli[47:36]), bad(scale_milli[35:24]),
        bad(scale_milli[23:12]), bad(scale_milli[11:0])})
        else $error("scale clamp flag wrong");
endmodule // mom_mapper_chk
bind mom_mapper mom_mapper_chk chk (.sys_clk, .rst, .ce, .sample_valid, .integ_shift, .scale_milli, .servo_installed,
    .servo_en, .servo_code, .analog_code, .ttl_out, .scale_clamped, .result_valid, .pos_result);
`default_nettype wire

// [mom_counter.sv]
`default_nettype none
module mom_counter (
    input wire logic sys_clk,
    input wire logic ttl,
    output int edges,
    output int hi,
    output int lo
);
    timeunit 1ns;
    timeprecision 1ns;
    int run;
    logic last = 1'b0;
    // ------
    // counts whole cycles per level, as a reciprocal counter would
    // ------
    always @(posedge sys_clk) begin
        if (ttl !== last) begin
            if (last)
                hi <= run;
            else
                lo <= run;
            edges <= edges + (ttl ? 1 : 0);
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= ttl;
    end
endmodule // mom_counter
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [63:0] raw; logic [7:0] sel; logic [47:0] scl; logic [63:0] ana; logic [3:0] clp;} mom_row_t;
    typedef struct packed {logic [1:0] fm; logic [15:0] raw; logic [11:0] scl; int inc;} mom_frow_t;
    logic sys_clk = 1'b0, rst = 1'b1, sample_valid = 1'b0, servo_installed = 1'b1, servo_en = 1'b0;
    logic ce = 1'b1, quad_mode = 1'b0;
    logic [63:0] raw_sample = 64'h0, cal_offset = 64'h0;
    logic [3:0] integ_shift = 4'h0;
    logic [7:0] source_sel = 8'h0, freq_mode = 8'h0;
    logic [47:0] scale_milli = {4{12'h3e8}};
    logic [31:0] servo_code = 32'h0;
    wire [63:0] analog_code, cur_result, comp_result;
    wire [3:0] ttl_out, scale_clamped;
    wire result_valid;
    int failures = 0, checks = 0, edges, hi, lo, e0;
    mom_row_t rows[4] = '{
        '{64'hc000400080017fff, 8'h00, {4{12'h3e8}}, 64'hc000400080017fff, 4'h0},
        '{64'h20004000c0004000, 8'h00, 48'h0017d01f41f4, 64'h7fff200080017fff, 4'h0},
        '{64'h7ffe0002c0004000, 8'h55, 48'hfff0003e83e8, 64'h1fff03e8e0002000, 4'hc},
        '{64'h1000300010003000, 8'haa, {4{12'h3e8}}, 64'hc0004000c0004000, 4'h0}};
    mom_frow_t frows[7] = '{
        '{2'h0, 16'h0000, 12'h3e8, 32767 * 1311},
        '{2'h0, 16'h7fff, 12'h3e8, 65534 * 1311},
        '{2'h1, 16'h8001, 12'h3e8, 0},
        '{2'h1, 16'h4000, 12'h3e8, 16384 * 2621},
        '{2'h2, 16'h7fff, 12'h3e8, 0},
        '{2'h2, 16'h8001, 12'h001, 32'h40000000},
        '{2'h3, 16'h8001, 12'h3e8, 32767 * 2621}};
    // gains fixed at 1.0 and 0.5 so expected codes stay exact
    mom_mapper dut (.sys_clk, .rst, .ce, .sample_valid, .raw_sample, .integ_shift, .cal_gain({4{16'h4000}}),
        .cal_offset, .sens_gain({4{16'h2000}}), .sens_offset(64'h0), .quad_mode, .source_sel, .freq_mode,
        .scale_milli, .servo_installed, .servo_en, .servo_code, .analog_code, .ttl_out, .scale_clamped,
        .result_valid, .cur_result, .comp_result, .pos_result());
    mom_counter mon (.sys_clk, .ttl(ttl_out[0]), .edges, .hi, .lo);
    // ------
    // tasks
    // ------
    task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one count of slack: the window may cut a period
    task automatic chk_n(input int got, input int exp);
        checks++;
        if (got > exp + 1 || got < exp - 1) begin
            failures++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [63:0] raw);
        raw_sample <= raw;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        for (int n = 0; n < 40 && result_valid !== 1'b1; n++) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------
    // stimulus
    // ------
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #500us;
        failures++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            source_sel <= rows[i].sel;
            scale_milli <= rows[i].scl;
            load(rows[i].raw);
            chk_v(analog_code, rows[i].ana);
            chk_v(scale_clamped, rows[i].clp);
        end
        foreach (frows[i]) begin
            freq_mode <= {6'h0, frows[i].fm};
            source_sel <= 8'h00;
            scale_milli <= {36'h3e83e83e8, frows[i].scl};
            load({48'h0, frows[i].raw});
            repeat (220) @(posedge sys_clk);
            e0 = edges;
            repeat (400) @(posedge sys_clk);
            chk_n(edges - e0, int'((longint'(frows[i].inc) * 400) >> 32));
            if (frows[i].inc != 0) begin
                chk_n(hi, lo);
                chk_n(hi + lo, int'(64'h100000000 / frows[i].inc));
            end
        end
        quad_mode <= 1'b1;
        source_sel <= 8'haa;
        load(64'h0000000020004000);
        chk_v(analog_code, 64'h7fff2aaa7fff2aaa);
        chk_v(comp_result, 64'h0000000010002000);
        ce <= 1'b0;
        repeat (2) @(posedge sys_clk);
        e0 = edges;
        repeat (300) @(posedge sys_clk);
        chk_v(edges - e0, 64'h0);
        chk_v(analog_code, 64'h7fff2aaa7fff2aaa);
        ce <= 1'b1;
        source_sel <= 8'h00;
        scale_milli <= {4{12'h3e8}};
        servo_code <= 32'h12340ace;
        servo_en <= 1'b1;
        load(64'h2000100000000000);
        chk_v(analog_code, 64'h2000100012340ace);
        servo_en <= 1'b0;
        integ_shift <= 4'h1;
        cal_offset <= 64'h0100;
        raw_sample <= 64'h1000;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        load(64'h3000);
        chk_v(cur_result, 64'h1f00);
        rst <= 1'b1;
        @(posedge sys_clk);
        chk_v(analog_code, 64'h0);
        chk_v({ttl_out, result_valid}, 64'h0);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk_v(analog_code, 64'h0);
        test_done;
    end
endmodule // tb
`default_nettype wire
